// *** inc/ats_regs.vh ***
// Constants for the converter trigger sequencer: field codes,
// divider and conversion timing counts.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef ATS_REGS_VH
`define ATS_REGS_VH

////////////////////////////////////////////////////////////////////
// Clock and conversion timing
`define ATS_CLK_PERIOD_NS  50
`define ATS_DIV_RATIO      32
`define ATS_DIV_W          5
`define ATS_DIV_LAST       5'h1F
`define ATS_CONV_TIME_NS   54000
`define ATS_CONV_CLKS      ((`ATS_CONV_TIME_NS + `ATS_CLK_PERIOD_NS * `ATS_DIV_RATIO - 1) / (`ATS_CLK_PERIOD_NS * `ATS_DIV_RATIO))
`define ATS_STAB_CLKS      6'h08
`define ATS_CNT_W          6

////////////////////////////////////////////////////////////////////
// Resolution
`define ATS_RES_W          12
`define ATS_RES_12         1'b0
`define ATS_BITS_12        4'hC
`define ATS_BITS_8         4'h8

////////////////////////////////////////////////////////////////////
// Trigger mode {hi,lo}
`define ATS_TMD_SOFT       2'h0
`define ATS_TMD_HW_NOWAIT  2'h2
`define ATS_TMD_HW_WAIT    2'h3

////////////////////////////////////////////////////////////////////
// Trigger source {hi,lo}; code 0 selects timer channel 1
`define ATS_TRS_TIMER1     2'h0

////////////////////////////////////////////////////////////////////
// Reference and channel selection
`define ATS_REFP_AVDD      2'h0
`define ATS_REFM_AVSS      1'b0
`define ATS_CH_W           5
`define ATS_MUX_W          6
`define ATS_MD_SELECT      1'b0
`define ATS_SCAN_LAST      2'h3
`define ATS_CFG_RST        1'b0

`endif

// *** core/ats_sequencer.v ***
// Converter trigger sequencer: configuration latch, state sequencing,
// conversion clock divider and successive-approximation control.
// Assumes comparator output is asynchronous; triggers and software
// control levels come from logic on the same clock.
`timescale 1ns/10ps
`include "ats_regs.vh"

module ats_sequencer
(
   // Clock and reset
   input  wire                   clk,
   input  wire                   reset,
   // Peripheral enable
   input  wire                   conv_clock_supply_en,
   // Mode register 2 fields
   input  wire                   pos_ref_sel_hi,
   input  wire                   pos_ref_sel_lo,
   input  wire                   neg_ref_sel,
   input  wire                   resolution_sel,
   // Mode register 1 fields
   input  wire                   trig_mode_hi,
   input  wire                   trig_mode_lo,
   input  wire                   trig_source_hi,
   input  wire                   trig_source_lo,
   input  wire                   oneshot_sel,
   // Mode register 0 fields
   input  wire                   channel_sel_mode,
   input  wire                   comparator_enable,
   input  wire                   conversion_start,
   // Channel specification
   input  wire                   internal_source_sel,
   input  wire [`ATS_CH_W-1:0]   input_channel_reg,
   // Hardware trigger events
   input  wire                   timer_ch1_event,
   input  wire [2:0]             trig_alt_events,
   // Analog side
   input  wire                   comp_in,
   output reg  [`ATS_MUX_W-1:0]  analog_mux_sel,
   output reg  [1:0]             pos_ref_out,
   output reg                    neg_ref_out,
   output reg                    sample_hold,
   output reg  [`ATS_RES_W-1:0]  sar_dac_code,
   // Result and status
   output reg  [`ATS_RES_W-1:0]  conversion_result_reg,
   output reg                    conv_end_irq,
   output wire                   conv_ready,
   output wire                   conv_waiting,
   output wire                   conv_busy,
   output wire                   conversion_clock
);

   ////////////////////////////////////////////////////////////////////
   // State codes
   localparam [2:0] ST_STOP   = 3'h0;  // Comparator disabled
   localparam [2:0] ST_READY  = 3'h1;  // Settings applied, awaiting start
   localparam [2:0] ST_WAIT   = 3'h2;  // Awaiting hardware trigger
   localparam [2:0] ST_STAB   = 3'h3;  // Stabilisation in wait mode
   localparam [2:0] ST_SAMPLE = 3'h4;  // Sampling the input
   localparam [2:0] ST_CONV   = 3'h5;  // Bit trials
   localparam [2:0] ST_STORE  = 3'h6;  // Result write
   localparam [2:0] ST_IRQ    = 3'h7;  // End-of-conversion pulse

   ////////////////////////////////////////////////////////////////////
   // Declarations
   reg  [2:0]              state_reg;      // Current state
   reg  [2:0]              state_next;     // Next state
   reg  [`ATS_DIV_W-1:0]   div_reg;        // Conversion clock divider
   reg  [`ATS_CNT_W-1:0]   cnt_reg;        // Phase counter
   reg  [`ATS_CNT_W-1:0]   cnt_next;       // Next phase count
   reg  [3:0]              bit_reg;        // Current trial bit
   reg  [3:0]              bit_next;       // Next trial bit
   reg  [`ATS_RES_W-1:0]   sar_next;       // Next trial code
   reg  [1:0]              scan_reg;       // Scan offset
   reg  [1:0]              scan_next;      // Next scan offset
   reg                     start_d_reg;    // Start delayed for edge
   reg                     comp_s1_reg;    // Comparator sync stage 1
   reg                     comp_s2_reg;    // Comparator sync stage 2
   reg  [1:0]              tmd_reg;        // Latched trigger mode
   reg  [1:0]              trs_reg;        // Latched trigger source
   reg                     res_reg;        // Latched resolution
   reg                     oneshot_reg;    // Latched one-shot select
   reg                     md_reg;         // Latched channel mode
   reg                     trig_sel;       // Selected trigger event
   wire                    conv_tick;      // Conversion clock enable
   wire                    start_rise;     // Start set this cycle
   wire                    hw_mode;        // Hardware trigger mode
   wire [3:0]              res_bits;       // Bits per conversion
   wire [`ATS_CNT_W-1:0]   sample_len;     // Sampling length
   wire [31:0]             conv_total;     // Whole conversion length, full width

   ////////////////////////////////////////////////////////////////////
   // Derived controls
   assign hw_mode    = tmd_reg[1];
   assign res_bits   = (res_reg == `ATS_RES_12) ? `ATS_BITS_12 : `ATS_BITS_8;
   assign conv_total = `ATS_CONV_CLKS;
   // Sampling fills what the trials and the store leave
   assign sample_len = conv_total[`ATS_CNT_W-1:0] - {2'h0, res_bits} - 6'h01;
   assign start_rise = conversion_start & ~start_d_reg;
   assign conv_tick  = (div_reg == `ATS_DIV_LAST);
   assign conversion_clock = conv_tick;
   assign conv_ready   = (state_reg == ST_READY);
   assign conv_waiting = (state_reg == ST_WAIT);
   assign conv_busy    = (state_reg == ST_STAB) | (state_reg == ST_SAMPLE) |
                         (state_reg == ST_CONV) | (state_reg == ST_STORE);

   ////////////////////////////////////////////////////////////////////
   // Trigger source selection
   always @*
   begin
      case ({trs_reg})
         `ATS_TRS_TIMER1 : trig_sel = timer_ch1_event;
         2'h1            : trig_sel = trig_alt_events[0];
         2'h2            : trig_sel = trig_alt_events[1];
         default         : trig_sel = trig_alt_events[2];
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Comparator synchroniser
   always @(posedge clk)
   begin
      if (reset)
      begin
         comp_s1_reg <= 1'b0;
         comp_s2_reg <= 1'b0;
      end
      else
      begin
         comp_s1_reg <= comp_in;
         comp_s2_reg <= comp_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration latch, applied only while the clock supply is on
   always @(posedge clk)
   begin
      if (reset)
      begin
         tmd_reg     <= {2{`ATS_CFG_RST}};
         trs_reg     <= {2{`ATS_CFG_RST}};
         res_reg     <= `ATS_CFG_RST;
         oneshot_reg <= `ATS_CFG_RST;
         md_reg      <= `ATS_CFG_RST;
         pos_ref_out <= `ATS_REFP_AVDD;
         neg_ref_out <= `ATS_REFM_AVSS;
         start_d_reg <= 1'b0;
      end
      else if (conv_clock_supply_en)
      begin
         start_d_reg <= conversion_start;
         // Settings are taken while stopped or idle, not mid-sequence
         if (state_reg == ST_STOP || state_reg == ST_READY)
         begin
            tmd_reg     <= {trig_mode_hi, trig_mode_lo};
            trs_reg     <= {trig_source_hi, trig_source_lo};
            res_reg     <= resolution_sel;
            oneshot_reg <= oneshot_sel;
            md_reg      <= channel_sel_mode;
            pos_ref_out <= {pos_ref_sel_hi, pos_ref_sel_lo};
            neg_ref_out <= neg_ref_sel;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Conversion clock divider, restarted at each conversion
   always @(posedge clk)
   begin
      if (reset || !conv_clock_supply_en)
         div_reg <= {`ATS_DIV_W{1'b0}};
      else if (!conv_busy)                              // Held at zero between conversions
         div_reg <= {`ATS_DIV_W{1'b0}};
      else
         div_reg <= div_reg + {{(`ATS_DIV_W-1){1'b0}}, 1'b1};
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always @*
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      bit_next   = bit_reg;
      sar_next   = sar_dac_code;
      scan_next  = scan_reg;
      case (state_reg)
         ST_STOP :
         begin
            // Comparator enable applies settings and readies
            if (comparator_enable)
               state_next = ST_READY;
         end
         ST_READY :
         begin
            scan_next = 2'h0;
            if (!comparator_enable)
               state_next = ST_STOP;
            else if (conversion_start && hw_mode)
               state_next = ST_WAIT;
            else if (start_rise && !hw_mode)
            begin
               // Software trigger starts at once
               state_next = ST_SAMPLE;
               cnt_next   = sample_len;
            end
         end
         ST_WAIT :
         begin
            // A second start write is a no-op here
            if (!conversion_start)
               state_next = ST_READY;
            else if (trig_sel)
            begin
               if (tmd_reg == `ATS_TMD_HW_WAIT)
               begin
                  state_next = ST_STAB;
                  cnt_next   = `ATS_STAB_CLKS;
               end
               else
               begin
                  state_next = ST_SAMPLE;
                  cnt_next   = sample_len;
               end
            end
         end
         ST_STAB :
         begin
            if (conv_tick)
            begin
               if (cnt_reg == 6'h01)
               begin
                  state_next = ST_SAMPLE;
                  cnt_next   = sample_len;
               end
               else
                  cnt_next = cnt_reg - 6'h01;
            end
         end
         ST_SAMPLE :
         begin
            if (conv_tick)
            begin
               if (cnt_reg == 6'h01)
               begin
                  // First trial: most significant bit set
                  state_next = ST_CONV;
                  bit_next   = res_bits - 4'h1;
                  sar_next   = {`ATS_RES_W{1'b0}};
                  sar_next[res_bits - 4'h1] = 1'b1;
               end
               else
                  cnt_next = cnt_reg - 6'h01;
            end
         end
         ST_CONV :
         begin
            if (conv_tick)
            begin
               // Comparator high keeps the trial bit
               if (!comp_s2_reg)
                  sar_next[bit_reg] = 1'b0;
               if (bit_reg == 4'h0)
                  state_next = ST_STORE;
               else
               begin
                  bit_next = bit_reg - 4'h1;
                  sar_next[bit_reg - 4'h1] = 1'b1;
               end
            end
         end
         ST_STORE :
            state_next = ST_IRQ;
         ST_IRQ :
         begin
            // Scan mode steps through four channels, one per conversion, then wraps
            if (md_reg != `ATS_MD_SELECT && scan_reg != `ATS_SCAN_LAST)
               scan_next = scan_reg + 2'h1;
            else
               scan_next = 2'h0;
            if (!conversion_start)
               state_next = ST_READY;
            else if (oneshot_reg && !hw_mode)
               state_next = ST_READY;
            else if (oneshot_reg)
               state_next = ST_WAIT;
            else
            begin
               // Sequential: convert again without a trigger
               state_next = ST_SAMPLE;
               cnt_next   = sample_len;
            end
         end
         default :
            state_next = ST_STOP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer registers
   always @(posedge clk)
   begin
      if (reset)
      begin
         state_reg    <= ST_STOP;
         cnt_reg      <= {`ATS_CNT_W{1'b0}};
         bit_reg      <= 4'h0;
         scan_reg     <= 2'h0;
         sar_dac_code <= {`ATS_RES_W{1'b0}};
      end
      else if (!conv_clock_supply_en)
      begin
         state_reg <= ST_STOP;
      end
      else if (!comparator_enable && state_reg != ST_READY)
      begin
         // Comparator off aborts any activity
         state_reg <= ST_STOP;
      end
      else if (!conversion_start && conv_busy)
      begin
         // Start cleared mid-conversion: abandon it
         state_reg <= ST_READY;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         bit_reg      <= bit_next;
         scan_reg     <= scan_next;
         sar_dac_code <= sar_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Result store, interrupt pulse, sample switch and channel mux
   always @(posedge clk)
   begin
      if (reset)
      begin
         conversion_result_reg <= {`ATS_RES_W{1'b0}};
         conv_end_irq          <= 1'b0;
         sample_hold           <= 1'b0;
         analog_mux_sel        <= {`ATS_MUX_W{1'b0}};
      end
      else
      begin
         // Result written on entering store, a cycle ahead of the interrupt
         if (state_reg == ST_CONV && state_next == ST_STORE && conv_clock_supply_en &&
             comparator_enable && conversion_start)
            conversion_result_reg <= sar_next;
         conv_end_irq <= (state_reg == ST_STORE) & conv_clock_supply_en
                         & comparator_enable & conversion_start;
         sample_hold  <= (state_next == ST_SAMPLE) & conv_clock_supply_en;
         // Select mode: named channel only
         if (md_reg == `ATS_MD_SELECT || internal_source_sel)
            analog_mux_sel <= {internal_source_sel, input_channel_reg};
         else
            analog_mux_sel <= {1'b0, input_channel_reg + {3'h0, scan_reg}};
      end
   end

endmodule // ats_sequencer

// *** testbench/ats_far_side.sv ***
// Far-side model: interval timer trigger and amplifier level at the comparator.
// Assumes the converter's clock; bench sets level and timer run.
`timescale 1ns/10ps
module ats_far_side
#(
   parameter PERIOD = 20000               // Clocks per timer interval
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Bench controls
   input  wire        run,
   input  wire [11:0] level,
   // Converter side
   input  wire [11:0] sar_dac_code,
   output reg         timer_ch1_event,
   output wire        comp_in
);
   reg [15:0] tick_cnt_reg;               // Interval count

   // Comparator high while input at or above trial code
   assign comp_in = (level >= sar_dac_code);

   // Interval timer with one-clock count-end pulse
   always @(posedge clk)
   begin
      if (reset || !run)
      begin
         tick_cnt_reg    <= 16'h0000;
         timer_ch1_event <= 1'b0;
      end
      else
      begin
         timer_ch1_event <= (tick_cnt_reg == PERIOD - 1);
         tick_cnt_reg    <= (tick_cnt_reg == PERIOD - 1) ? 16'h0000 : tick_cnt_reg + 16'h0001;
      end
   end
endmodule // ats_far_side

// *** testbench/ats_sequencer_asserts.sv ***
// Port-level checks of the converter trigger sequencer.
// Assumes binding into ats_sequencer; sees its ports only.
`timescale 1ns/10ps
module ats_seq_asserts
(
   // Clock and reset
   input wire       clk,
   input wire       reset,
   // Control levels
   input wire       conv_clock_supply_en,
   input wire       trig_mode_hi,
   input wire       trig_source_hi,
   input wire       trig_source_lo,
   input wire       oneshot_sel,
   input wire       comparator_enable,
   input wire       conversion_start,
   // Trigger events
   input wire       timer_ch1_event,
   input wire [2:0] trig_alt_events,
   // Status
   input wire       sample_hold,
   input wire       conv_end_irq,
   input wire       conv_ready,
   input wire       conv_waiting,
   input wire       conv_busy,
   input wire       conversion_clock
);
   localparam int LEN_MIN = 1056;         // 33 divided clocks
   localparam int LEN_MAX = 1122;         // 35 divided clocks plus two clocks
   reg  [7:0]  div_cnt_reg;               // Clocks since divided clock
   reg  [10:0] busy_len_reg;              // Clocks spent busy
   wire        go = conv_clock_supply_en && comparator_enable && conversion_start;
   wire        idle = !conv_ready && !conv_waiting && !conv_busy && !conv_end_irq;
   wire        trig_hit = trig_source_hi ? (trig_source_lo ? trig_alt_events[2] : trig_alt_events[1])
                                         : (trig_source_lo ? trig_alt_events[0] : timer_ch1_event);

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Divider spacing and conversion length counters
   always @(posedge clk)
   begin
      if (reset)
      begin
         div_cnt_reg  <= 8'h00;
         busy_len_reg <= 11'h000;
      end
      else
      begin
         div_cnt_reg  <= !conv_busy ? 8'h01 : (conversion_clock ? 8'h01 : div_cnt_reg + 8'h01);
         busy_len_reg <= conv_busy ? busy_len_reg + 11'h001 : 11'h000;
      end
   end

   sequence s_accept;
      conv_waiting && go && trig_hit;
   endsequence
   sequence s_sample;
      conv_busy && sample_hold;
   endsequence

   chk_supply_stop: assert property (!conv_clock_supply_en |=> !conv_ready && !conv_waiting && !conv_busy)
      else $error("converter active without clock supply");
   chk_enable_ready: assert property (idle && comparator_enable && conv_clock_supply_en |=> conv_ready)
      else $error("enable did not reach ready");
   chk_start_waits: assert property (conv_ready && go && trig_mode_hi |=> conv_waiting && !conv_busy)
      else $error("start did not wait for trigger");
   chk_wait_holds: assert property (conv_waiting && go && !trig_hit |=> conv_waiting && !conv_busy)
      else $error("conversion without trigger");
   chk_trig_starts: assert property (s_accept |=> s_sample)
      else $error("trigger did not start sampling");
   chk_idle_ignore: assert property (trig_mode_hi && !conversion_start && !conv_busy |=> !conv_busy)
      else $error("conversion with start clear");
   chk_irq_after_store: assert property (conv_end_irq |-> !conv_busy && $past(conv_busy))
      else $error("interrupt not after conversion");
   chk_irq_pulse: assert property (conv_end_irq |=> !conv_end_irq)
      else $error("interrupt longer than one clock");
   chk_oneshot_wait: assert property (conv_end_irq && oneshot_sel && trig_mode_hi && go |-> ##[0:1] conv_waiting)
      else $error("no return to trigger wait");
   chk_div_32: assert property (conversion_clock |-> conv_busy && div_cnt_reg == 8'h20)
      else $error("divided clock spacing wrong");
   chk_conv_time: assert property (conv_end_irq |-> busy_len_reg >= LEN_MIN && busy_len_reg <= LEN_MAX)
      else $error("conversion length out of range");
endmodule // ats_seq_asserts

bind ats_sequencer ats_seq_asserts ats_seq_asserts_inst
(
   .clk, .reset, .conv_clock_supply_en, .trig_mode_hi, .trig_source_hi, .trig_source_lo, .oneshot_sel,
   .comparator_enable, .conversion_start, .timer_ch1_event, .trig_alt_events, .sample_hold, .conv_end_irq,
   .conv_ready, .conv_waiting, .conv_busy, .conversion_clock
);

// *** testbench/ats_sequencer_test.sv ***
// Self-checking bench of the converter trigger sequencer.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/10ps
`include "ats_regs.vh"
module ats_sequencer_test;
   reg         clk = 1'b0, reset = 1'b1, timer_run = 1'b0;
   reg         conv_clock_supply_en = 1'b1, pos_ref_sel_hi = 1'b0, pos_ref_sel_lo = 1'b0, neg_ref_sel = 1'b0;
   reg         resolution_sel = 1'b0, trig_mode_hi = 1'b1, trig_mode_lo = 1'b0, trig_source_hi = 1'b0;
   reg         trig_source_lo = 1'b0, oneshot_sel = 1'b1, channel_sel_mode = 1'b0, comparator_enable = 1'b0;
   reg         conversion_start = 1'b0, internal_source_sel = 1'b0;
   reg  [4:0]  input_channel_reg = 5'h02;    // Channel 2
   reg  [2:0]  trig_alt_events = 3'h0;
   reg  [11:0] analog_level = 12'hFFF;       // Full-scale corner first
   wire [5:0]  analog_mux_sel;
   wire [1:0]  pos_ref_out;
   wire [11:0] sar_dac_code, conversion_result_reg;
   wire        neg_ref_out, sample_hold, conv_end_irq, conv_ready, conv_waiting, conv_busy;
   wire        conversion_clock, comp_in, timer_ch1_event;
   integer     n_fail = 0, checks = 0, i, s;
   time        t_irq;

   ats_sequencer ats_sequencer_inst (.clk, .reset, .conv_clock_supply_en, .pos_ref_sel_hi, .pos_ref_sel_lo,
      .neg_ref_sel, .resolution_sel, .trig_mode_hi, .trig_mode_lo, .trig_source_hi, .trig_source_lo,
      .oneshot_sel, .channel_sel_mode, .comparator_enable, .conversion_start, .internal_source_sel,
      .input_channel_reg, .timer_ch1_event, .trig_alt_events, .comp_in, .analog_mux_sel, .pos_ref_out,
      .neg_ref_out, .sample_hold, .sar_dac_code, .conversion_result_reg, .conv_end_irq, .conv_ready,
      .conv_waiting, .conv_busy, .conversion_clock);
   ats_far_side #(.PERIOD(20000)) ats_far_side_inst (.clk, .reset, .run(timer_run), .level(analog_level),
      .sar_dac_code, .timer_ch1_event, .comp_in);

   // 20 MHz clock
   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////
   // Counts a comparison, reports a mismatch
   task check(input reg ok, input string msg);
   begin
      checks = checks + 1;
      if (!ok)
      begin
         n_fail = n_fail + 1;
         $display("[ERR] %0t %s", $time, msg);
      end
   end
   endtask

   // Verdict and end of run
   task print_verdict;
   begin
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   // Bounded wait for the end-of-conversion pulse
   task wait_irq(input integer max);
      integer w;
   begin
      w = 0;
      while (conv_end_irq !== 1'b1 && w < max)
      begin
         @(negedge clk);
         w = w + 1;
      end
      check(w < max, "no end-of-conversion pulse");
   end
   endtask

   // One-clock pulse on an alternate trigger line
   task alt_pulse(input integer b);
   begin
      @(negedge clk);
      trig_alt_events = 3'h1 << b;
      @(negedge clk);
      trig_alt_events = 3'h0;
   end
   endtask

   // Expected MSB-first successive approximation result
   function [11:0] exp_sar(input [11:0] lv);
      integer b;
      reg [11:0] c;
   begin
      c = 12'h000;
      for (b = 11; b >= 0; b = b - 1)
         if (lv >= (c | (12'h001 << b)))
            c = c | (12'h001 << b);
      exp_sar = c;
   end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      s = $urandom(80551);
      repeat (2) @(negedge clk);
      reset = 1'b0;
      check(conv_ready === 1'b0 && conv_end_irq === 1'b0 && conversion_result_reg === 12'h000, "reset state");
      comparator_enable = 1'b1;
      @(negedge clk);
      check(conv_ready === 1'b1, "not ready after enable");
      conversion_start = 1'b1;
      @(negedge clk);
      check(conv_waiting === 1'b1 && conv_busy === 1'b0, "start began converting");
      repeat (5) @(negedge clk);
      check(conv_waiting === 1'b1 && conv_busy === 1'b0, "converting without trigger");
      // Timer-paced one-shot conversions of channel 2
      timer_run = 1'b1;
      for (i = 0; i < 3; i = i + 1)
      begin
         wait_irq(22000);
         check(conversion_result_reg === exp_sar(analog_level), "result mismatch");
         check(analog_mux_sel === 6'h02 && pos_ref_out === 2'h0 && neg_ref_out === 1'b0, "settings");
         if (i > 0)
            check($time - t_irq == 1000000, "conversion spacing not 1 ms");
         t_irq = $time;
         analog_level = (i == 0) ? 12'h000 : $urandom;
         @(negedge clk);
         check(conv_waiting === 1'b1 && conversion_start === 1'b1, "no wait after one-shot");
      end
      timer_run = 1'b0;
      // Start cleared: triggers ignored
      conversion_start = 1'b0;
      @(negedge clk);
      trig_source_lo = 1'b1;
      alt_pulse(0);
      check(conv_busy === 1'b0, "trigger taken with start clear");
      // Alternate sources with random settings
      for (s = 1; s < 4; s = s + 1)
      begin
         {trig_source_hi, trig_source_lo} = s[1:0];
         {pos_ref_sel_hi, pos_ref_sel_lo, neg_ref_sel} = $urandom % 8;
         input_channel_reg = $urandom % 32;
         analog_level = $urandom % 4096;
         conversion_start = 1'b1;
         alt_pulse(s % 3);
         check(conv_busy === 1'b0, "other source started a conversion");
         alt_pulse(s - 1);
         check(conv_busy === 1'b1 && sample_hold === 1'b1, "selected trigger ignored");
         wait_irq(1500);
         check(conversion_result_reg === exp_sar(analog_level), "result mismatch");
         check(analog_mux_sel === {1'b0, input_channel_reg}, "channel not latched");
         check(pos_ref_out === {pos_ref_sel_hi, pos_ref_sel_lo} && neg_ref_out === neg_ref_sel, "refs");
         conversion_start = 1'b0;
         @(negedge clk);
      end
      // Software trigger, one-shot: back to ready after the pulse
      trig_mode_hi = 1'b0;
      analog_level = 12'h5A5;
      @(negedge clk);
      conversion_start = 1'b1;
      wait_irq(1500);
      check(conversion_result_reg === exp_sar(analog_level), "software result");
      @(negedge clk);
      check(conv_ready === 1'b1 && conv_waiting === 1'b0, "one-shot did not stop");
      conv_clock_supply_en = 1'b0;
      @(negedge clk);
      check(conv_ready === 1'b0 && conv_waiting === 1'b0 && conv_busy === 1'b0, "active unclocked");
      print_verdict;
   end

   // Watchdog against a hang
   initial
   begin
      #(90000 * 50);
      check(1'b0, "watchdog expired");
      print_verdict;
   end
endmodule // ats_sequencer_test
